//--- common/pio_pkg.sv
// Constants for the parallel I/O port set
// Notes on behaviour
// RQ1: Output values are held in a latch until software writes again.
// RQ2: Pin reads return the present synchronised level, never a captured copy.
// RQ3: Outside sources hold inputs steady or software samples several times.
// RQ4: Pins are sampled during the read cycle; no strobe marks it.
// RQ5: Written output data appears on pins the cycle after the write.
// RQ6: A pin in output mode drives its output data bit.
// RQ7: A pin in input mode reads back its current level.
// RQ8: Direction bit 0 means input, 1 means output.
// RQ9: Alternate-output enable routes the peripheral output; 0 gives plain port output.
// RQ10: Driver type bit selects push-pull or open drain per pin.
// RQ11: Pull-up connects only in input mode or open drain.
// RQ12: Some ports lack the driver-type or alternate-enable register.
// RQ13: Eight ports, 42 pins, widths four, eight or two.
// RQ14: First four-bit port carries oscillator connections when selected.
// RQ15: Second four-bit port carries reset, interrupt and stop-release inputs.
// RQ16: One eight-bit port shares pins with UART and serial interfaces.
// RQ17: Another eight-bit port shares pins with analog and key wakeup inputs.
// RQ18: A further eight-bit port shares timer, divider output and interrupts.
// RQ19: A four-bit high port is an alternative UART and serial placement.
// RQ20: Every configuration bit acts on its own pin only.
package pio_pkg;
  localparam int NUM_PORTS = 8;
  localparam int NUM_PINS = 42;
  localparam int PORT_W = 8;
  localparam int NUM_REGS = 6;
  // Port widths and first pin index within the flat pin vector
  localparam int PORT_WIDTH [NUM_PORTS] = '{4, 4, 8, 8, 8, 4, 2, 4};
  localparam int PORT_BASE [NUM_PORTS] = '{0, 4, 8, 16, 24, 32, 36, 38};
  // Which ports implement the driver-type and alternate-enable registers
  localparam logic [7:0] HAS_DRVTYPE = 8'hc4;
  localparam logic [7:0] HAS_ALTEN = 8'hfd;
  // Register kinds within a port block; byte address = (port*8 + kind)*4
  localparam logic [2:0] REG_OUT_DATA = 3'h0;
  localparam logic [2:0] REG_PIN_READ = 3'h1;
  localparam logic [2:0] REG_DIRECTION = 3'h2;
  localparam logic [2:0] REG_ALT_EN = 3'h3;
  localparam logic [2:0] REG_DRV_TYPE = 3'h4;
  localparam logic [2:0] REG_PULLUP = 3'h5;
  localparam int ADDR_W = 8;
  localparam logic [7:0] RST_VALUE = 8'h00;
  localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
endpackage

//--- dv/parallel_io_port_set_tb_top.sv
// Self-checking bench for the parallel I/O port set
`timescale 1ns/10ps
module parallel_io_port_set_tb_top;
  import pio_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] readdata;
  logic waitrequest;
  logic [NUM_PINS-1:0] pinIn, pinOut, pinOe, pinPullupEn, pinLevel;
  logic [NUM_PINS-1:0] altOut = '0, altOe = '0, extVal = '0;
  logic [15:0] lfsr = 16'h9068;
  int mdl [8][8];
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  pio_port_set pio_port_set_inst (.clk(clk), .resetn(resetn), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .pinPullupEn(pinPullupEn), .altOut(altOut), .altOe(altOe),
    .pinLevel(pinLevel));
  pio_board_model pio_board_model_inst (.pinOut(pinOut), .pinOe(pinOe), .extVal(extVal),
    .pinIn(pinIn));
  always #10 clk = ~clk;
  // Hang guard; the run needs about three and a half thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  function automatic logic [31:0] rnd();
    for (int i = 0; i < 32; i++)
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return {lfsr, lfsr ^ 16'h5a5a};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // Avalon master: hold the request until waitrequest is seen low
  task automatic bus(input logic wr, input int a, input logic [31:0] d, output logic [31:0] q);
    int n = 0;
    address <= 8'(a);
    writedata <= d;
    write <= wr;
    read <= ~wr;
    byteenable <= {3'h7, d[31]};
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    if (n >= 50) err_count++;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk);
  endtask
  // Writes land only with byteenable bit 0 and on implemented places
  task automatic wr(input int p, input int k, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, (p * 8 + k) * 4, d, q);
    if (d[31] && k != 1 && k < 6 && (k != 3 || HAS_ALTEN[p]) && (k != 4 || HAS_DRVTYPE[p]))
      mdl[p][k] = d & ((1 << PORT_WIDTH[p]) - 1);
  endtask
  // Pin drive from the model, optionally followed by a read of every register
  task automatic sweep(input bit regs);
    logic [31:0] q;
    int x;
    @(negedge clk);
    for (int p = 0; p < NUM_PORTS; p++) begin
      x = 0;
      for (int b = 0; b < PORT_WIDTH[p]; b++) begin
        int i = PORT_BASE[p] + b;
        logic al, v, e, od;
        al = mdl[p][3][b];
        v = al ? altOut[i] : mdl[p][0][b];
        e = al ? altOe[i] : mdl[p][2][b];
        od = mdl[p][4][b];
        chk(pinOe[i], e & ~(od & v), "enable");
        if (e & ~od) chk(pinOut[i], v, "drive");
        chk(pinPullupEn[i], mdl[p][5][b] & (~e | od), "pullup");
        x[b] = (e & ~od) ? v : (e & od & ~v) ? 1'b0 : extVal[i];
      end
      if (regs) @(posedge clk);
      for (int k = 0; k < 7 && regs; k++) begin
        bus(1'b0, (p * 8 + k) * 4, 32'h0, q);
        chk(q, k == 1 ? x : mdl[p][k], "register");
      end
    end
    @(posedge clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    logic [63:0] t;
    mdl = '{default: 0};
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    sweep(1'b1);
    // Random rounds over every port and register kind, read-only and unmapped too
    for (int r = 0; r < 8; r++) begin
      t = {rnd(), rnd()};
      extVal <= t[41:0];
      t = {rnd(), rnd()};
      altOut <= t[41:0];
      altOe <= t[63:22];
      repeat (8) @(posedge clk);
      for (int p = 0; p < NUM_PORTS; p++)
        for (int k = 0; k < 7; k++) begin
          wr(p, k, rnd());
          sweep(1'b0);
        end
      repeat (8) @(posedge clk);
      sweep(1'b1);
    end
    wrap_up();
  end
endmodule

//--- dv/pio_board_model.sv
// Board model that resolves each port pin level
`timescale 1ns/10ps
module pio_board_model
  import pio_pkg::*;
(
  // Pin drive from the port set
  input wire logic [pio_pkg::NUM_PINS-1:0] pinOut,
  input wire logic [pio_pkg::NUM_PINS-1:0] pinOe,
  // Levels held by outside sources
  input wire logic [pio_pkg::NUM_PINS-1:0] extVal,
  // Resolved level seen by the port set
  output logic [pio_pkg::NUM_PINS-1:0] pinIn
);
  // The device wins where it drives; outside sources hold steady until read
  assign pinIn = (pinOe & pinOut) | (~pinOe & extVal);
endmodule

//--- rtl/pio_port_set.sv
// Parallel I/O port set with Avalon-MM register access
`timescale 1ns/10ps
module pio_port_set
  import pio_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Avalon-MM slave
  input wire logic [pio_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Port pins
  input wire logic [pio_pkg::NUM_PINS-1:0] pinIn,
  output logic [pio_pkg::NUM_PINS-1:0] pinOut,
  output logic [pio_pkg::NUM_PINS-1:0] pinOe,
  output logic [pio_pkg::NUM_PINS-1:0] pinPullupEn,
  // Secondary function outputs from peripherals
  input wire logic [pio_pkg::NUM_PINS-1:0] altOut, // RQ14 RQ15 RQ16 RQ17 RQ18 RQ19
  input wire logic [pio_pkg::NUM_PINS-1:0] altOe,
  // Synchronised pin levels for peripherals
  output logic [pio_pkg::NUM_PINS-1:0] pinLevel
);
  import pio_pkg::*;

  // Bus decode
  logic [2:0] portIdx;
  logic [2:0] kindIdx;
  logic busReq;
  logic pendingFf;
  assign portIdx = address[7:5];
  assign kindIdx = address[4:2];
  assign busReq = read | write;

  // Per-port configuration, flattened to pin vectors
  logic [NUM_PINS-1:0] outDataFf;
  logic [NUM_PINS-1:0] dirFf;
  logic [NUM_PINS-1:0] altEnFf;
  logic [NUM_PINS-1:0] drvOdFf;
  logic [NUM_PINS-1:0] pullFf;

  // Three-stage input synchroniser; a change is taken when stage 2 and 3 agree
  logic [NUM_PINS-1:0] sync1Ff;
  logic [NUM_PINS-1:0] sync2Ff;
  logic [NUM_PINS-1:0] sync3Ff;
  logic [NUM_PINS-1:0] levelFf;
  logic [NUM_PINS-1:0] nxt_level;
  assign nxt_level = (sync2Ff & sync3Ff) | (levelFf & (sync2Ff | sync3Ff));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1Ff <= '0;
      sync2Ff <= '0;
      sync3Ff <= '0;
      levelFf <= '0;
    end else begin
      sync1Ff <= pinIn;
      sync2Ff <= sync1Ff;
      sync3Ff <= sync2Ff;
      levelFf <= nxt_level; // RQ2
    end
  end

  // One wait cycle per access so read data come from a flop
  assign waitrequest = busReq & ~pendingFf;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pendingFf <= 1'b0;
    end else begin
      pendingFf <= busReq & ~pendingFf;
    end
  end

  logic wrStrobe;
  logic rdStrobe;
  assign wrStrobe = write & pendingFf & byteenable[0];
  assign rdStrobe = read & ~pendingFf;

  // Per-port register logic
  logic [7:0] portRead [NUM_PORTS];
  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
      localparam int W = PORT_WIDTH[p]; // RQ13
      localparam int B = PORT_BASE[p];
      logic hit;
      logic [W-1:0] wdat;
      assign hit = wrStrobe && (portIdx == 3'(p));
      assign wdat = writedata[W-1:0];
      // Only this port's own bits are touched by a write
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          outDataFf[B +: W] <= RST_VALUE[W-1:0];
          dirFf[B +: W] <= RST_VALUE[W-1:0];
          altEnFf[B +: W] <= RST_VALUE[W-1:0];
          drvOdFf[B +: W] <= RST_VALUE[W-1:0];
          pullFf[B +: W] <= RST_VALUE[W-1:0];
        end else if (hit) begin
          if (kindIdx == REG_OUT_DATA) outDataFf[B +: W] <= wdat; // RQ1
          if (kindIdx == REG_DIRECTION) dirFf[B +: W] <= wdat; // RQ8
          if (kindIdx == REG_ALT_EN && HAS_ALTEN[p]) altEnFf[B +: W] <= wdat; // RQ12
          if (kindIdx == REG_DRV_TYPE && HAS_DRVTYPE[p]) drvOdFf[B +: W] <= wdat; // RQ12
          if (kindIdx == REG_PULLUP) pullFf[B +: W] <= wdat;
        end
      end
      // Readback mux; missing registers read as zero
      logic [W-1:0] sel;
      assign sel = (kindIdx == REG_OUT_DATA) ? outDataFf[B +: W] :
                   (kindIdx == REG_PIN_READ) ? levelFf[B +: W] : // RQ7
                   (kindIdx == REG_DIRECTION) ? dirFf[B +: W] :
                   (kindIdx == REG_ALT_EN) ? altEnFf[B +: W] :
                   (kindIdx == REG_DRV_TYPE) ? drvOdFf[B +: W] :
                   (kindIdx == REG_PULLUP) ? pullFf[B +: W] : '0;
      if (W < PORT_W) begin : g_pad
        assign portRead[p] = {{(PORT_W-W){1'b0}}, sel};
      end else begin : g_full
        assign portRead[p] = sel;
      end
    end
  endgenerate

  // Read data, sampled in the access's first cycle; no strobe leaves the block
  logic mapped;
  assign mapped = (kindIdx < 3'(NUM_REGS)) && (address[1:0] == 2'b00);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      readdata <= UNMAPPED_DATA;
    end else if (rdStrobe) begin
      readdata <= mapped ? {24'h000000, portRead[portIdx]} : UNMAPPED_DATA; // RQ4
    end
  end

  // Pin drive: alternate output when enabled, otherwise the port latch
  logic [NUM_PINS-1:0] srcVal;
  logic [NUM_PINS-1:0] srcOe;
  logic [NUM_PINS-1:0] nxt_oe;
  logic [NUM_PINS-1:0] nxt_out;
  logic [NUM_PINS-1:0] nxt_pull;
  assign srcVal = (altEnFf & altOut) | (~altEnFf & outDataFf); // RQ9 RQ6 RQ20
  assign srcOe = (altEnFf & altOe) | (~altEnFf & dirFf); // RQ8
  // Open drain only ever drives low
  assign nxt_oe = srcOe & (~drvOdFf | ~srcVal); // RQ10
  assign nxt_out = srcVal & ~drvOdFf;
  assign nxt_pull = pullFf & (~srcOe | drvOdFf); // RQ11

  // Registered pins: a write shows one cycle after it lands
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinOut <= '0;
      pinOe <= '0;
      pinPullupEn <= '0;
      pinLevel <= '0;
    end else begin
      pinOut <= nxt_out; // RQ5
      pinOe <= nxt_oe;
      pinPullupEn <= nxt_pull;
      pinLevel <= levelFf;
    end
  end

  // Assertions
  sequence wr_out_s;
    write && pendingFf && byteenable[0] && kindIdx == REG_OUT_DATA && portIdx == 3'd2;
  endsequence
  out_follows_a: assert property (@(posedge clk) disable iff (!resetn) // RQ5
    wr_out_s ##2 (!altEnFf[8] && !drvOdFf[8]) |-> pinOut[8] == $past(writedata[0], 2))
    else $error("output data not on pin two cycles after write");
  dir_input_a: assert property (@(posedge clk) disable iff (!resetn) // RQ8
    (!dirFf[0] && !altEnFf[0]) |=> !pinOe[0])
    else $error("input pin driven");
  od_high_a: assert property (@(posedge clk) disable iff (!resetn) // RQ10
    drvOdFf[8] |=> !pinOut[8])
    else $error("open drain pin drove high");
  pull_gate_a: assert property (@(posedge clk) disable iff (!resetn) // RQ11
    (dirFf[3] && !altEnFf[3] && !drvOdFf[3]) |=> !pinPullupEn[3])
    else $error("pullup on push-pull output");
  latch_hold_a: assert property (@(posedge clk) disable iff (!resetn) // RQ1
    !(wrStrobe && portIdx == 3'd0) |=> $stable(outDataFf[3:0]))
    else $error("output latch changed without write");
  no_alten_a: assert property (@(posedge clk) disable iff (!resetn) // RQ12
    altEnFf[7:4] == 4'h0)
    else $error("missing alternate enable register written");
  wait_one_a: assert property (@(posedge clk) disable iff (!resetn) // RQ4
    (busReq && !pendingFf) |=> !waitrequest)
    else $error("access not answered in one wait cycle");
  read_live_a: assert property (@(posedge clk) disable iff (!resetn) // RQ7
    (rdStrobe && kindIdx == REG_PIN_READ && portIdx == 3'd6 && mapped)
      |=> readdata[1:0] == $past(levelFf[37:36]))
    else $error("pin read not current level");
  own_pin_a: assert property (@(posedge clk) disable iff (!resetn) // RQ20
    (dirFf[9] && !altEnFf[9] && !drvOdFf[9]) |=> pinOe[9])
    else $error("output pin not driven");

  // Alternate output takes the pin value when enabled
  alt_drive_a: assert property (@(posedge clk) disable iff (!resetn) // RQ9
    (altEnFf[8] && !drvOdFf[8]) |=> pinOut[8] == $past(altOut[8]))
    else $error("alternate value not on pin");

  // Plain port output follows the latch when the alternate path is off
  plain_drive_a: assert property (@(posedge clk) disable iff (!resetn) // RQ6
    !altEnFf[16] |=> pinOut[16] == $past(outDataFf[16]))
    else $error("latch value not on pin");

  // Alternate enable also hands the driver enable to the peripheral
  alt_oe_a: assert property (@(posedge clk) disable iff (!resetn) // RQ9
    altEnFf[24] |=> pinOe[24] == $past(altOe[24]))
    else $error("alternate enable not on pin");

  // Pull-up stays on for an input pin that asks for it
  in_pull_a: assert property (@(posedge clk) disable iff (!resetn) // RQ11
    (!dirFf[16] && !altEnFf[16] && pullFf[16]) |=> pinPullupEn[16])
    else $error("pullup missing on input pin");

  // Open drain pulls low when the data bit is zero
  od_low_a: assert property (@(posedge clk) disable iff (!resetn) // RQ10
    (drvOdFf[8] && !altEnFf[8] && dirFf[8] && !outDataFf[8]) |=> pinOe[8])
    else $error("open drain did not pull low");

  // Open drain releases the pin for a one
  od_release_a: assert property (@(posedge clk) disable iff (!resetn) // RQ10
    (drvOdFf[8] && !altEnFf[8] && outDataFf[8]) |=> !pinOe[8])
    else $error("open drain drove a one");

  // Peripherals see the filtered level one cycle later
  level_copy_a: assert property (@(posedge clk) disable iff (!resetn) // RQ2
    1'b1 |=> pinLevel == $past(levelFf))
    else $error("peripheral level stale");

  // Agreeing stages are taken at once, so reads stay current
  sync_agree_a: assert property (@(posedge clk) disable iff (!resetn) // RQ2
    (sync2Ff == sync3Ff) |=> levelFf == $past(sync2Ff))
    else $error("agreed level not taken");

  // A disagreeing bit keeps its last level; this is the glitch filter
  sync_hold_a: assert property (@(posedge clk) disable iff (!resetn) // RQ2
    (sync2Ff[0] != sync3Ff[0]) |=> levelFf[0] == $past(levelFf[0]))
    else $error("level moved on disagreement");

  // Direction writes land on their own port
  wr_dir_a: assert property (@(posedge clk) disable iff (!resetn) // RQ8
    (wrStrobe && kindIdx == REG_DIRECTION && portIdx == 3'd3)
      |=> dirFf[23:16] == $past(writedata[7:0]))
    else $error("direction write lost");

  // Ports without a driver-type register stay push-pull
  no_drvtype_a: assert property (@(posedge clk) disable iff (!resetn) // RQ12
    drvOdFf[7:0] == 8'h00 && drvOdFf[35:16] == 20'h00000)
    else $error("missing driver type register written");

  // Unmapped places read as zero
  unmapped_rd_a: assert property (@(posedge clk) disable iff (!resetn) // RQ4
    (rdStrobe && !mapped) |=> readdata == UNMAPPED_DATA)
    else $error("unmapped read not zero");

  // Narrow ports pad their read data with zeros
  pad_zero_a: assert property (@(posedge clk) disable iff (!resetn) // RQ13
    (rdStrobe && portIdx == 3'd6) |=> readdata[31:2] == 30'h00000000)
    else $error("narrow port read not padded");

  // A write to one port leaves the others alone
  other_port_a: assert property (@(posedge clk) disable iff (!resetn) // RQ20
    !(wrStrobe && portIdx == 3'd2) |=> $stable(outDataFf[15:8]))
    else $error("foreign write reached port latch");

  // Read data stand until the next read
  rd_hold_a: assert property (@(posedge clk) disable iff (!resetn) // RQ4
    !rdStrobe |=> $stable(readdata))
    else $error("read data moved without read");

  // A write without its low byte lane changes nothing
  wr_nobe_a: assert property (@(posedge clk) disable iff (!resetn) // RQ1
    (write && pendingFf && !byteenable[0]) |=> $stable(outDataFf) && $stable(dirFf))
    else $error("write without lane landed");
endmodule
